// ---- src/rpm_pkg.sv ----
package rpm_pkg;
    // ------------------------------------------------------------
    // Pin function encodings
    // ------------------------------------------------------------
    // Pin function: primary (port or reset) or alternate
    typedef enum logic {
        RPM_FUNC_PRIMARY,
        RPM_FUNC_ALTERNATE
    } rpm_func_type;

    // ------------------------------------------------------------
    // Widths and counts
    // ------------------------------------------------------------
    localparam int RPM_LOW_PINS = 4;
    // Internal clocks between end of external request and release
    localparam int RPM_RELEASE_CYCLES = 16;
    localparam logic [4:0] RPM_RELEASE_LAST = 5'(RPM_RELEASE_CYCLES - 1);
    localparam logic [4:0] RPM_CNT_ZERO = 5'h00;
    localparam logic [4:0] RPM_CNT_ONE = 5'h01;
    // Reset values of the software controls
    localparam logic RPM_RST_FUNC = 1'b0;
    localparam logic [3:0] RPM_RST_DIR = 4'h0;
    localparam logic [3:0] RPM_RST_DATA = 4'h0;

    // Per-pin pad drive bundle
    typedef struct packed {
        logic [3:0] out;
        logic [3:0] oe;
    } rpm_pad_drive_type;
endpackage

// ---- src/rpm_reset_pin_and_port_a_mux.sv ----
// Operation
// - Leaving reset, every pin takes primary function
// - Alternate function only after software selects it
// - Low reset pin holds chip in reset
// - Release reset synchronously, fixed clocks after request
// - Reset pin as port bit: input or open-drain
// - Reset pin in port mode ignores reset action
// - Port bits 0-3 have independent direction
// - Alternate function on port bits 0-3 drives matching pulse channel, output only
module rpm_reset_pin_and_port_a_mux #(
    parameter int RELEASE_CYCLES = rpm_pkg::RPM_RELEASE_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_srst,
    // Other reset sources: power-on, watchdog, software
    input wire logic i_por_rst,
    input wire logic i_watchdog_reset_source,
    input wire logic i_soft_rst,
    // Reset pad, active low in reset role
    input wire logic i_reset_pin_n,
    // Software controls
    input wire logic i_rst_pin_func_sel,
    input wire logic i_rst_pin_out_low,
    input wire logic [3:0] i_low_func_sel,
    input wire logic [3:0] i_low_dir_out,
    input wire logic [3:0] i_low_data_out,
    // Pulse channels zero to three from the motor-control timer
    input wire logic [3:0] i_pulse_out,
    // Low port pads
    input wire logic [3:0] i_low_pad_in,
    output logic [3:0] o_low_pad_out,
    output logic [3:0] o_low_pad_oe,
    output logic [3:0] o_low_pad_in_data,
    // Reset pad as port bit
    output logic o_reset_pin_port_bit_out,
    output logic o_reset_pin_port_bit_oe,
    output logic o_reset_pin_port_bit_in_data,
    // Chip-wide internal reset, active high
    output logic o_chip_rst
);
    // ------------------------------------------------------------
    // Reset pin synchroniser
    // ------------------------------------------------------------
    // Three stages; change counts once stages two and three agree
    // The pad is asynchronous to i_clk, so stage one may go metastable;
    // only stages two and three feed the filter below.
    logic [2:0] rpin_sync_q; // Shift chain, bit 0 nearest the pad
    logic rpin_level_q; // Filtered pad level, high is idle
    logic rpin_level_d; // Next filtered level
    // Shift chain has no reset: it refills from the pad in three clocks
    always_ff @(posedge i_clk) begin
        rpin_sync_q <= {rpin_sync_q[1:0], i_reset_pin_n};
    end
    // Two agreeing stages move the level; a lone glitch is held off
    assign rpin_level_d = (rpin_sync_q[2] == rpin_sync_q[1]) ? rpin_sync_q[2] : rpin_level_q;
    // Filter register; idle high so leaving reset sees no false request
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            rpin_level_q <= 1'b1;
        end else begin
            rpin_level_q <= rpin_level_d;
        end
    end

    // ------------------------------------------------------------
    // Function selects
    // ------------------------------------------------------------
    // Registered so the pads see one clean edge per change
    // Software may change the selects in any cycle; a register between
    // the controls and the pad mux keeps decode hazards off the pads.
    rpm_pkg::rpm_func_type rst_func_q; // Reset pad role
    logic [3:0] low_func_q; // Per bit: 1 selects the pulse channel
    logic [3:0] dir_q; // Per bit: 1 drives the pad
    logic [3:0] data_q; // Port output data
    logic rst_low_q; // Pull reset pad low in port mode
    logic chip_rst_q; // Internal reset, high while any source holds
    wire any_rst = i_srst | chip_rst_q;
    // Controls are frozen at their reset values while internal reset holds
    always_ff @(posedge i_clk) begin
        if (any_rst) begin
            rst_func_q <= rpm_pkg::RPM_FUNC_PRIMARY;
            low_func_q <= {rpm_pkg::RPM_LOW_PINS{rpm_pkg::RPM_RST_FUNC}};
            dir_q <= rpm_pkg::RPM_RST_DIR;
            data_q <= rpm_pkg::RPM_RST_DATA;
            rst_low_q <= 1'b0;
        end else begin
            // Only a software write moves a pin off primary
            rst_func_q <= rpm_pkg::rpm_func_type'(i_rst_pin_func_sel);
            low_func_q <= i_low_func_sel;
            dir_q <= i_low_dir_out;
            data_q <= i_low_data_out;
            rst_low_q <= i_rst_pin_out_low;
        end
    end

    // ------------------------------------------------------------
    // Internal reset generation
    // ------------------------------------------------------------
    // Pin request only counts in reset role
    wire pin_rst_req = (rst_func_q == rpm_pkg::RPM_FUNC_PRIMARY) & ~rpin_level_q;
    // Power-on, watchdog and software reset act in either pad role
    wire other_rst_req = i_por_rst | i_watchdog_reset_source | i_soft_rst;
    wire rst_req = pin_rst_req | other_rst_req | i_srst;
    logic [4:0] rel_cnt_q; // Clocks counted since the last request
    // Limitation: the counter is five bits, so RELEASE_CYCLES must stay at or below 32
    wire [4:0] rel_last = 5'(RELEASE_CYCLES - 1);
    // Any new request restarts the count, so release is always a full count late
    always_ff @(posedge i_clk) begin
        if (rst_req) begin
            // Held in reset while any source asserts
            chip_rst_q <= 1'b1;
            rel_cnt_q <= rpm_pkg::RPM_CNT_ZERO;
        end else if (chip_rst_q) begin
            // Count clocks before a synchronous release
            if (rel_cnt_q == rel_last) begin
                chip_rst_q <= 1'b0;
            end
            rel_cnt_q <= rel_cnt_q + rpm_pkg::RPM_CNT_ONE;
        end
    end
    assign o_chip_rst = chip_rst_q;

    // ------------------------------------------------------------
    // Pad drive selection
    // ------------------------------------------------------------
    rpm_pkg::rpm_pad_drive_type drv_d; // Next pad drive
    rpm_pkg::rpm_pad_drive_type drv_q; // Pad drive flops, no logic after them
    // Alternate: pulse channel, always output; primary: port direction
    assign drv_d.out = (low_func_q & i_pulse_out) | (~low_func_q & data_q);
    assign drv_d.oe = low_func_q | dir_q;
    // Pads released during reset; the pull-ups then hold the lines
    // The trade-off is one clock of latency for a glitch-free pad
    always_ff @(posedge i_clk) begin
        if (any_rst) begin
            drv_q <= '0;
        end else begin
            drv_q <= drv_d;
        end
    end
    assign o_low_pad_out = drv_q.out;
    assign o_low_pad_oe = drv_q.oe;
    assign o_low_pad_in_data = i_low_pad_in;

    // Open drain: only ever pulls low, never drives high
    logic rpo_oe_q; // Pull-low enable for the reset pad
    // Enable only in port mode; in reset role the pad is an input
    always_ff @(posedge i_clk) begin
        if (any_rst) begin
            rpo_oe_q <= 1'b0;
        end else begin
            rpo_oe_q <= (rst_func_q == rpm_pkg::RPM_FUNC_ALTERNATE) & rst_low_q;
        end
    end
    assign o_reset_pin_port_bit_out = 1'b0;
    assign o_reset_pin_port_bit_oe = rpo_oe_q;
    assign o_reset_pin_port_bit_in_data = rpin_level_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_primary_after_rst: assert property (@(posedge i_clk) disable iff (i_srst)
        $fell(chip_rst_q) |-> rst_func_q == rpm_pkg::RPM_FUNC_PRIMARY)
        else $error("reset pin not primary after reset");
    a_no_alt_in_rst: assert property (@(posedge i_clk) disable iff (i_srst)
        chip_rst_q |=> drv_q.oe == (low_func_q | dir_q) || chip_rst_q)
        else $error("pad drive changed without selection");
    a_pin_holds_rst: assert property (@(posedge i_clk) disable iff (i_srst)
        pin_rst_req |=> chip_rst_q)
        else $error("reset pin low did not hold reset");
    sequence s_req_end;
        rst_req ##1 !rst_req;
    endsequence
    a_release_count: assert property (@(posedge i_clk) disable iff (i_srst)
        s_req_end ##0 (!rst_req)[*3] |-> chip_rst_q)
        else $error("reset released too early");
    a_open_drain: assert property (@(posedge i_clk)
        o_reset_pin_port_bit_oe |-> !o_reset_pin_port_bit_out)
        else $error("reset pin driven high");
    // A low pad in port mode must not start an internal reset
    a_port_mode_ignore: assert property (@(posedge i_clk) disable iff (i_srst)
        (rst_func_q == rpm_pkg::RPM_FUNC_ALTERNATE && !other_rst_req && !chip_rst_q) |=> !chip_rst_q)
        else $error("reset acted in port mode");
    // Pads stay released once internal reset has held for one clock
    a_pads_off_rst: assert property (@(posedge i_clk) disable iff (i_srst)
        chip_rst_q && $past(chip_rst_q) |-> drv_q == '0 && !rpo_oe_q)
        else $error("pad driven during reset");
    // The pull-low enable only follows a port-mode selection
    a_oe_needs_sel: assert property (@(posedge i_clk) disable iff (i_srst)
        o_reset_pin_port_bit_oe |-> $past(rst_func_q == rpm_pkg::RPM_FUNC_ALTERNATE))
        else $error("reset pad pulled low in reset role");
    // Port pin 1 with primary function only drives when its direction says so
    a_primary_dir: assert property (@(posedge i_clk) disable iff (i_srst)
        !any_rst && !$past(any_rst) && !$past(low_func_q[1]) |->
        o_low_pad_oe[1] == $past(dir_q[1]) && o_low_pad_out[1] == $past(data_q[1]))
        else $error("primary pin drive wrong");
    a_dir_independent: assert property (@(posedge i_clk) disable iff (i_srst)
        !any_rst && !$past(any_rst) |-> o_low_pad_oe == ($past(low_func_q) | $past(dir_q)))
        else $error("direction not per pin");
    a_pulse_output: assert property (@(posedge i_clk) disable iff (i_srst)
        !any_rst && !$past(any_rst) && $past(low_func_q[0]) |->
        o_low_pad_oe[0] && o_low_pad_out[0] == $past(i_pulse_out[0]))
        else $error("pulse channel not on pad");
    a_sel_reset: assert property (@(posedge i_clk)
        $past(any_rst) |-> low_func_q == '0)
        else $error("function select not reset");
endmodule

// ---- testbench/rpm_board_model.sv ----
// ------------------------------------------------------------
// Board side: pull-ups, external drivers, reset button
// ------------------------------------------------------------
module rpm_board_model (
    input wire logic [3:0] i_pad_out, // Device drive value
    input wire logic [3:0] i_pad_oe, // Device drive enable
    input wire logic [3:0] i_ext_val, // Board level when device lets go
    input wire logic i_rst_oe, // Device pulls reset pad low
    input wire logic i_button, // Reset button pressed
    output logic [3:0] o_pad_level,
    output logic o_reset_pin_n
);
    timeunit 1ns;
    timeprecision 1ns;
    // Driven bits follow the device, released bits follow the board
    assign o_pad_level = (i_pad_out & i_pad_oe) | (i_ext_val & ~i_pad_oe);
    // Pull-up wins unless button or device pulls low
    assign o_reset_pin_n = ~(i_button | i_rst_oe);
endmodule

// ---- testbench/rpm_reset_pin_and_port_a_mux_test.sv ----
module rpm_reset_pin_and_port_a_mux_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int REL = 4; // Short release count keeps the run brief
    typedef struct packed {rpm_pkg::rpm_pad_drive_type pad; logic rst_oe; logic chip_rst;} rpm_note_type;
    logic i_clk = 1'b0, i_srst = 1'b1, take = 1'b0, button = 1'b0, rsel = 1'b0, rlow = 1'b0;
    logic [2:0] src = 3'h0; // Power-on, watchdog, software requests
    logic [3:0] fsel = 4'hF, dir = 4'hF, dat = 4'hF, pls = 4'hF, ext = 4'h0, lvl, pout, poe, pin;
    logic rst_n, rout, roe, rin, chip_rst;
    int error_cnt = 0, samples_checked = 0, n;
    rpm_note_type exp_q[$];
    always #50 i_clk = ~i_clk;
    rpm_reset_pin_and_port_a_mux #(.RELEASE_CYCLES(REL)) i_dut (.i_clk(i_clk), .i_srst(i_srst),
        .i_por_rst(src[0]), .i_watchdog_reset_source(src[1]), .i_soft_rst(src[2]), .i_reset_pin_n(rst_n),
        .i_rst_pin_func_sel(rsel), .i_rst_pin_out_low(rlow), .i_low_func_sel(fsel), .i_low_dir_out(dir),
        .i_low_data_out(dat), .i_pulse_out(pls), .i_low_pad_in(lvl), .o_low_pad_out(pout), .o_low_pad_oe(poe),
        .o_low_pad_in_data(pin), .o_reset_pin_port_bit_out(rout), .o_reset_pin_port_bit_oe(roe),
        .o_reset_pin_port_bit_in_data(rin), .o_chip_rst(chip_rst));
    rpm_board_model i_board (.i_pad_out(pout), .i_pad_oe(poe), .i_ext_val(ext), .i_rst_oe(roe),
        .i_button(button), .o_pad_level(lvl), .o_reset_pin_n(rst_n));
    // ------------------------------------------------------------
    // Checking
    // ------------------------------------------------------------
    task automatic results();
        if (error_cnt == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk_bits(input logic [7:0] act, input logic [7:0] exp);
        samples_checked++;
        if (act !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t act=%0h exp=%0h", $time, act, exp);
        end
    endtask
    // Monitor: oldest note against the settled outputs
    always @(posedge i_clk) begin
        if (take) begin
            chk_bits({pout, poe}, exp_q[0].pad);
            chk_bits({roe, chip_rst}, {exp_q[0].rst_oe, exp_q[0].chip_rst});
            void'(exp_q.pop_front());
        end
    end
    // Outputs land two edges after a control change
    task automatic note();
        repeat (2) @(negedge i_clk);
        exp_q.push_back({(fsel & pls) | (~fsel & dat), fsel | dir, rsel & rlow, 1'b0});
        take = 1'b1;
        @(negedge i_clk);
        take = 1'b0;
    endtask
    // Bounded wait for the internal reset to reach a level
    task automatic wait_rst(input logic want);
        n = 0;
        while (chip_rst !== want) begin
            @(negedge i_clk);
            n++;
            if (n > 60) begin
                error_cnt++;
                results();
            end
        end
    endtask
    // ------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'h9BFC967A));
        repeat (12) @(negedge i_clk);
        chk_bits({poe, roe, chip_rst}, 8'h01);
        i_srst = 1'b0;
        wait_rst(1'b0);
        chk_bits(8'((n >= REL) && (n <= REL + 2)), 8'h01);
        for (int k = 0; k < 16; k++) begin
            {fsel, dir, dat, pls, ext} = 20'($urandom());
            note();
            chk_bits(8'(pin), 8'((pout & poe) | (ext & ~poe)));
        end
        button = 1'b1;
        wait_rst(1'b1);
        // Pad flops clear one clock after internal reset rises
        @(negedge i_clk);
        chk_bits({poe, roe}, 8'h00);
        button = 1'b0;
        wait_rst(1'b0);
        chk_bits(8'((n >= REL) && (n <= REL + 8)), 8'h01);
        rsel = 1'b1;
        note();
        button = 1'b1;
        repeat (30) begin
            @(negedge i_clk);
            chk_bits(8'(chip_rst), 8'h00);
        end
        chk_bits(8'(rin), 8'h00);
        button = 1'b0;
        rlow = 1'b1;
        note();
        chk_bits({rout, rin}, 8'h00);
        rlow = 1'b0;
        for (int k = 0; k < 3; k++) begin
            src = 3'(1 << k);
            wait_rst(1'b1);
            src = 3'h0;
            wait_rst(1'b0);
        end
        results();
    end
endmodule
